// [vocf_top.sv]
`timescale 1ns/10ps
// Behaviour
// - Field output polarity follows control bit
// - Clock-invert bit inverts output clock
// - Selector picks half, single, double, 90-degree clock
// - Pixel repetition divides single-rate clock further
// - Output mode routes pixel data to pins
// - Secondary port driven only when enabled in 4:2:2 and DDR modes; in 4:4:4 it follows the primary enable
// - S/PDIF three-stated by its control bit
// - I2S and MCLK three-stated by control bit
// - Power-down pin polarity set by control bit
module vocf_top
    import vocf_pkg::*;
(
    // Clock and reset
    input wire logic CLOCK_I,
    input wire logic RST_B_I,
    // 2-wire control port
    input wire logic SCL_I,
    input wire logic SDA_I,
    output logic SDA_O,
    output logic SDA_OE_O,
    // Recovered video and audio
    input wire logic [23:0] PIX444_I,
    input wire logic [15:0] PIX422_I,
    input wire logic HSYNC_I,
    input wire logic VSYNC_I,
    input wire logic DE_I,
    input wire logic FIELD_I,
    input wire logic PIXEL_REP_I,
    input wire logic SPDIF_I,
    input wire logic [3:0] I2S_SD_I,
    input wire logic I2S_SCLK_I,
    input wire logic I2S_LRCLK_I,
    input wire logic MCLK_I,
    input wire logic PWRDN_PIN_I,
    // Video outputs
    output logic [7:0] VID_RED_O,
    output logic [7:0] VID_GRN_O,
    output logic [7:0] VID_BLU_O,
    output logic VID_PRI_OE_O,
    output logic VID_BLU_OE_O,
    output logic HSYNC_O,
    output logic VSYNC_O,
    output logic DE_O,
    output logic FIELD_O,
    output logic SYNC_OE_O,
    output logic DCLK_O,
    output logic DCLK_OE_O,
    // Audio outputs
    output logic SPDIF_O,
    output logic SPDIF_OE_O,
    output logic [3:0] I2S_SD_O,
    output logic I2S_SCLK_O,
    output logic I2S_LRCLK_O,
    output logic MCLK_O,
    output logic I2S_OE_O,
    // Power-down request
    output logic POWER_DOWN_O
);
    vocf_state_e state_q;
    logic scl_q, sda_q, rw_q;
    logic [3:0] bitc_q;
    logic [7:0] sh_q, ptr_q;
    logic [7:0] pol_q, clkfmt_q, tripd_q;
    logic [2:0] ph_q;

    // Bus events, seen against the previous sample
    wire scl_rise = SCL_I & ~scl_q;
    wire scl_fall = ~SCL_I & scl_q;
    wire start_c = SCL_I & scl_q & sda_q & ~SDA_I;
    wire stop_c = SCL_I & scl_q & ~sda_q & SDA_I;
    wire byte_done = (bitc_q == VOCF_BITS_PER_BYTE);
    wire rx_state = (state_q == VOCF_ADDR) | (state_q == VOCF_SUB) | (state_q == VOCF_WDATA);
    wire addr_hit = (sh_q[7:1] == VOCF_DEV_ADDR);
    wire wr_en = (state_q == VOCF_WDATA) & scl_fall & byte_done;
    wire [7:0] rd_data = (ptr_q == VOCF_POL_OFS) ? pol_q :
                         (ptr_q == VOCF_CLKFMT_OFS) ? clkfmt_q :
                         (ptr_q == VOCF_TRIPD_OFS) ? tripd_q : 8'h00;

    // Serial slave: byte-wide access with auto-increment
    always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            state_q <= VOCF_IDLE;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            rw_q <= 1'b0;
            bitc_q <= 4'h0;
            sh_q <= 8'h00;
            ptr_q <= 8'h00;
            SDA_OE_O <= 1'b0;
        end else begin
            scl_q <= SCL_I;
            sda_q <= SDA_I;
            if (stop_c) begin
                state_q <= VOCF_IDLE;
                SDA_OE_O <= 1'b0;
            end else if (start_c) begin
                state_q <= VOCF_ADDR;
                bitc_q <= 4'h0;
                SDA_OE_O <= 1'b0;
            end else if (scl_rise) begin
                if (rx_state) begin
                    sh_q <= {sh_q[6:0], SDA_I};
                    bitc_q <= bitc_q + 4'h1;
                end else if (state_q == VOCF_RACK && SDA_I) begin
                    state_q <= VOCF_IDLE;
                end
            end else if (scl_fall) begin
                case (state_q)
                    VOCF_ADDR: begin
                        if (byte_done) begin
                            state_q <= addr_hit ? VOCF_ADDR_ACK : VOCF_IDLE;
                            SDA_OE_O <= addr_hit;
                            rw_q <= sh_q[0];
                        end
                    end
                    VOCF_SUB: begin
                        if (byte_done) begin
                            ptr_q <= sh_q;
                            state_q <= VOCF_SUB_ACK;
                            SDA_OE_O <= 1'b1;
                        end
                    end
                    VOCF_WDATA: begin
                        if (byte_done) begin
                            state_q <= VOCF_WACK;
                            SDA_OE_O <= 1'b1;
                        end
                    end
                    VOCF_ADDR_ACK, VOCF_RACK: begin
                        if (rw_q) begin
                            sh_q <= rd_data;
                            SDA_OE_O <= ~rd_data[7];
                            bitc_q <= 4'h1;
                            state_q <= VOCF_RDATA;
                        end else begin
                            SDA_OE_O <= 1'b0;
                            bitc_q <= 4'h0;
                            state_q <= VOCF_SUB;
                        end
                    end
                    VOCF_SUB_ACK, VOCF_WACK: begin
                        SDA_OE_O <= 1'b0;
                        bitc_q <= 4'h0;
                        state_q <= VOCF_WDATA;
                    end
                    VOCF_RDATA: begin
                        if (byte_done) begin
                            SDA_OE_O <= 1'b0;
                            ptr_q <= ptr_q + 8'h01;
                            state_q <= VOCF_RACK;
                        end else begin
                            SDA_OE_O <= ~sh_q[6];
                            sh_q <= {sh_q[6:0], 1'b0};
                            bitc_q <= bitc_q + 4'h1;
                        end
                    end
                    default: begin
                        state_q <= VOCF_IDLE;
                    end
                endcase
                if (wr_en) begin
                    ptr_q <= ptr_q + 8'h01;
                end
            end
        end
    end

    // Control registers; unimplemented bits read as zero
    always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            pol_q <= VOCF_POL_RST;
            clkfmt_q <= VOCF_CLKFMT_RST;
            tripd_q <= VOCF_TRIPD_RST;
        end else if (wr_en) begin
            if (ptr_q == VOCF_POL_OFS) pol_q <= sh_q & VOCF_POL_MASK;
            if (ptr_q == VOCF_CLKFMT_OFS) clkfmt_q <= sh_q & VOCF_CLKFMT_MASK;
            if (ptr_q == VOCF_TRIPD_OFS) tripd_q <= sh_q & VOCF_TRIPD_MASK;
        end
    end

    // Field decode
    wire [1:0] clk_sel = clkfmt_q[VOCF_CLK_SEL_HI:VOCF_CLK_SEL_LO];
    wire [1:0] mode = clkfmt_q[VOCF_MODE_HI:VOCF_MODE_LO];
    wire pri_en = clkfmt_q[VOCF_PRI_EN_BIT];
    wire sec_en = clkfmt_q[VOCF_SEC_EN_BIT];
    wire tri_all = tripd_q[VOCF_TRI_ALL_BIT];

    // CLOCK_I is four times the single rate; phase counter makes the rest
    wire one_x = PIXEL_REP_I ? ph_q[2] : ph_q[1];
    wire one_x_90 = PIXEL_REP_I ? (ph_q[2] ^ ph_q[1]) : (ph_q[1] ^ ph_q[0]);
    wire sel_clk = (clk_sel == VOCF_CLK_HALF) ? ph_q[2] :
                   (clk_sel == VOCF_CLK_ONE) ? one_x :
                   (clk_sel == VOCF_CLK_DOUBLE) ? ph_q[0] : one_x_90;
    // Invert bit lives in the polarity register, not beside the port enables
    wire clk_out = sel_clk ^ pol_q[VOCF_CLK_INV_BIT];
    // DDR halves follow the single-rate clock level
    wire hi_half = ~one_x;
    wire [7:0] ddr422 = hi_half ? PIX422_I[15:8] : PIX422_I[7:0];
    wire [11:0] ddr444 = hi_half ? PIX444_I[23:12] : PIX444_I[11:0];
    wire pri_on = pri_en & ~tri_all;
    wire blu_on = ((mode == VOCF_MODE_422) || (mode == VOCF_MODE_DDR444)) ?
                  (sec_en & ~tri_all) : pri_on;
    wire [7:0] red_d = (mode == VOCF_MODE_422) ? PIX422_I[15:8] :
                       (mode == VOCF_MODE_DDR444) ? ddr444[11:4] : PIX444_I[23:16];
    wire [7:0] grn_d = (mode == VOCF_MODE_422) ? PIX422_I[7:0] :
                       (mode == VOCF_MODE_DDR444) ? {ddr444[3:0], 4'h0} : PIX444_I[15:8];
    wire [7:0] blu_d = ((mode == VOCF_MODE_422) || (mode == VOCF_MODE_DDR444)) ?
                       ddr422 : PIX444_I[7:0];

    // Output stage, every pin from a flop
    always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            ph_q <= 3'h0;
            VID_RED_O <= 8'h00;
            VID_GRN_O <= 8'h00;
            VID_BLU_O <= 8'h00;
            VID_PRI_OE_O <= 1'b0;
            VID_BLU_OE_O <= 1'b0;
            HSYNC_O <= 1'b0;
            VSYNC_O <= 1'b0;
            DE_O <= 1'b0;
            FIELD_O <= 1'b0;
            SYNC_OE_O <= 1'b0;
            DCLK_O <= 1'b0;
            DCLK_OE_O <= 1'b0;
            SPDIF_O <= 1'b0;
            SPDIF_OE_O <= 1'b0;
            I2S_SD_O <= 4'h0;
            I2S_SCLK_O <= 1'b0;
            I2S_LRCLK_O <= 1'b0;
            MCLK_O <= 1'b0;
            I2S_OE_O <= 1'b0;
            POWER_DOWN_O <= 1'b0;
            SDA_O <= 1'b0;
        end else begin
            ph_q <= ph_q + 3'h1;
            // Disabled ports hold zero so a stale pixel never leaks out
            VID_RED_O <= pri_on ? red_d : 8'h00;
            VID_GRN_O <= pri_on ? grn_d : 8'h00;
            VID_BLU_O <= blu_on ? blu_d : 8'h00;
            VID_PRI_OE_O <= pri_on;
            VID_BLU_OE_O <= blu_on;
            HSYNC_O <= HSYNC_I;
            VSYNC_O <= VSYNC_I;
            DE_O <= DE_I;
            FIELD_O <= FIELD_I ^ ~pol_q[VOCF_FIELD_POL_BIT];
            SYNC_OE_O <= ~tri_all;
            DCLK_O <= clk_out;
            DCLK_OE_O <= ~tri_all;
            SPDIF_O <= SPDIF_I;
            SPDIF_OE_O <= ~tripd_q[VOCF_TRI_SPDIF_BIT];
            I2S_SD_O <= I2S_SD_I;
            I2S_SCLK_O <= I2S_SCLK_I;
            I2S_LRCLK_O <= I2S_LRCLK_I;
            MCLK_O <= MCLK_I;
            I2S_OE_O <= ~tripd_q[VOCF_TRI_I2S_BIT];
            POWER_DOWN_O <= PWRDN_PIN_I ^ ~tripd_q[VOCF_PD_POL_BIT];
            SDA_O <= 1'b0;
        end
    end
endmodule

// [vocf_pkg.sv]
package vocf_pkg;
    // Register offsets on the 2-wire control port
    localparam logic [7:0] VOCF_POL_OFS = 8'h24;
    localparam logic [7:0] VOCF_CLKFMT_OFS = 8'h25;
    localparam logic [7:0] VOCF_TRIPD_OFS = 8'h26;
    // Reset values and implemented-bit masks
    localparam logic [7:0] VOCF_POL_RST = 8'h10;
    localparam logic [7:0] VOCF_POL_MASK = 8'h11;
    localparam logic [7:0] VOCF_CLKFMT_RST = 8'h72;
    localparam logic [7:0] VOCF_CLKFMT_MASK = 8'hff;
    localparam logic [7:0] VOCF_TRIPD_RST = 8'h08;
    localparam logic [7:0] VOCF_TRIPD_MASK = 8'hb8;
    // Field positions
    localparam int VOCF_FIELD_POL_BIT = 4;
    localparam int VOCF_CLK_INV_BIT = 0;
    localparam int VOCF_CLK_SEL_HI = 7;
    localparam int VOCF_CLK_SEL_LO = 6;
    localparam int VOCF_MODE_HI = 3;
    localparam int VOCF_MODE_LO = 2;
    localparam int VOCF_PRI_EN_BIT = 1;
    localparam int VOCF_SEC_EN_BIT = 0;
    localparam int VOCF_TRI_ALL_BIT = 7;
    localparam int VOCF_TRI_SPDIF_BIT = 5;
    localparam int VOCF_TRI_I2S_BIT = 4;
    localparam int VOCF_PD_POL_BIT = 3;
    // Clock select and output mode codes
    localparam logic [1:0] VOCF_CLK_HALF = 2'h0;
    localparam logic [1:0] VOCF_CLK_ONE = 2'h1;
    localparam logic [1:0] VOCF_CLK_DOUBLE = 2'h2;
    localparam logic [1:0] VOCF_CLK_ONE_90 = 2'h3;
    localparam logic [1:0] VOCF_MODE_444 = 2'h0;
    localparam logic [1:0] VOCF_MODE_422 = 2'h1;
    localparam logic [1:0] VOCF_MODE_DDR444 = 2'h2;
    // Serial port device address, arbitrary value
    localparam logic [6:0] VOCF_DEV_ADDR = 7'h4c;
    localparam logic [3:0] VOCF_BITS_PER_BYTE = 4'h8;
    typedef enum logic [8:0] {
        VOCF_IDLE = 9'h001,
        VOCF_ADDR = 9'h002,
        VOCF_ADDR_ACK = 9'h004,
        VOCF_SUB = 9'h008,
        VOCF_SUB_ACK = 9'h010,
        VOCF_WDATA = 9'h020,
        VOCF_WACK = 9'h040,
        VOCF_RDATA = 9'h080,
        VOCF_RACK = 9'h100
    } vocf_state_e;
endpackage

// [vocf_top_props.sv]
`timescale 1ns/10ps
module vocf_top_props (
    input wire logic CLOCK_I, RST_B_I, SCL_I, SDA_O, SDA_OE_O,
    input wire logic HSYNC_I, VSYNC_I, DE_I, SPDIF_I, MCLK_I, I2S_SCLK_I, I2S_LRCLK_I,
    input wire logic [3:0] I2S_SD_I,
    input wire logic [7:0] VID_RED_O, VID_GRN_O, VID_BLU_O,
    input wire logic VID_PRI_OE_O, VID_BLU_OE_O, HSYNC_O, VSYNC_O, DE_O,
    input wire logic SYNC_OE_O, DCLK_O, DCLK_OE_O, SPDIF_O, SPDIF_OE_O, MCLK_O,
    input wire logic I2S_OE_O, I2S_SCLK_O, I2S_LRCLK_O,
    input wire logic [3:0] I2S_SD_O
);
    default clocking @(posedge CLOCK_I); endclocking
    default disable iff (!RST_B_I);
    sequence s_clk_running;
        DCLK_OE_O && $past(DCLK_OE_O);
    endsequence
    sequence s_clk_moves;
        ##[0:4] ($changed(DCLK_O) || !DCLK_OE_O);
    endsequence
    AST_SYNC_DELAY: assert property (SYNC_OE_O |-> HSYNC_O == $past(HSYNC_I)
        && VSYNC_O == $past(VSYNC_I) && DE_O == $past(DE_I)) else $error("sync path wrong");
    AST_I2S_DELAY: assert property (I2S_OE_O |-> MCLK_O == $past(MCLK_I)
        && I2S_SD_O == $past(I2S_SD_I) && I2S_SCLK_O == $past(I2S_SCLK_I)
        && I2S_LRCLK_O == $past(I2S_LRCLK_I)) else $error("audio path wrong");
    AST_SPDIF_DELAY: assert property (SPDIF_OE_O |-> SPDIF_O == $past(SPDIF_I))
        else $error("spdif path wrong");
    AST_PRI_QUIET: assert property (!VID_PRI_OE_O |-> VID_RED_O == 8'h00
        && VID_GRN_O == 8'h00) else $error("primary pins active while off");
    AST_BLU_QUIET: assert property (!VID_BLU_OE_O |-> VID_BLU_O == 8'h00)
        else $error("blue pins active while off");
    AST_GLOBAL_OFF: assert property (!SYNC_OE_O |-> !DCLK_OE_O && !VID_PRI_OE_O
        && !VID_BLU_OE_O) else $error("global three-state leaks");
    AST_CLK_TOGGLES: assert property (s_clk_running |-> s_clk_moves)
        else $error("output clock stuck");
    AST_SDA_ON_LOW: assert property ($changed(SDA_OE_O) |-> !SCL_I)
        else $error("data line moved while clock high");
    AST_SDA_PULL_LOW: assert property (SDA_OE_O |-> !SDA_O)
        else $error("data line driven high");
endmodule

bind vocf_top vocf_top_props u_props (.CLOCK_I(CLOCK_I), .RST_B_I(RST_B_I), .SCL_I(SCL_I),
    .SDA_OE_O(SDA_OE_O), .HSYNC_I(HSYNC_I), .VSYNC_I(VSYNC_I), .DE_I(DE_I),
    .SPDIF_I(SPDIF_I), .MCLK_I(MCLK_I), .I2S_SD_I(I2S_SD_I), .VID_RED_O(VID_RED_O),
    .VID_GRN_O(VID_GRN_O), .VID_BLU_O(VID_BLU_O), .VID_PRI_OE_O(VID_PRI_OE_O),
    .VID_BLU_OE_O(VID_BLU_OE_O), .HSYNC_O(HSYNC_O), .VSYNC_O(VSYNC_O), .DE_O(DE_O),
    .SYNC_OE_O(SYNC_OE_O), .DCLK_O(DCLK_O), .DCLK_OE_O(DCLK_OE_O), .SPDIF_O(SPDIF_O),
    .SPDIF_OE_O(SPDIF_OE_O), .MCLK_O(MCLK_O), .I2S_OE_O(I2S_OE_O), .I2S_SD_O(I2S_SD_O),
    .SDA_O(SDA_O), .I2S_SCLK_I(I2S_SCLK_I), .I2S_LRCLK_I(I2S_LRCLK_I),
    .I2S_SCLK_O(I2S_SCLK_O), .I2S_LRCLK_O(I2S_LRCLK_O));

// [vocf_disp.sv]
`timescale 1ns/10ps
module vocf_disp (
    input wire logic clk_i,
    input wire logic dclk_i,
    input wire logic dclk_oe_i,
    input wire logic pri_oe_i,
    input wire logic [7:0] red_i,
    output logic [7:0] red_o
);
    logic dclk_q;
    // Takes red on each rising output clock; undriven pins are never taken
    always @(posedge clk_i) begin
        dclk_q <= dclk_i;
        if (dclk_oe_i && pri_oe_i && dclk_i && !dclk_q) begin
            red_o <= red_i;
        end
    end
endmodule

// [video_output_config_tb.sv]
`timescale 1ns/10ps
module video_output_config_tb;
    import vocf_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic scl = 1'b1;
    logic sda_m = 1'b1;
    logic [7:0] cnt = 8'h00;
    logic [8:0] rx;
    logic fld_in = 1'b1;
    logic pin = 1'b1;
    logic rep = 1'b0;
    logic [2:0] ref_ph = 3'h0;
    int failures = 0;
    int n_checks = 0;
    wire logic sda_oe, spdif_oe, i2s_oe, sync_oe, dclk_oe, dclk, pri_oe, blu_oe, fld, pd;
    wire logic [7:0] red, blu, disp_red;
    // Open-drain line: master and device can only pull low
    wire logic sda_w = sda_m & ~sda_oe;
    always #5 clk = ~clk;
    always @(negedge clk) cnt <= cnt + 8'h01;
    // Phase count of the output clock divider, cleared while reset is held
    always @(posedge clk) ref_ph <= rst_b ? ref_ph + 3'h1 : 3'h0;
    vocf_top uut (.CLOCK_I(clk), .RST_B_I(rst_b), .SCL_I(scl), .SDA_I(sda_w), .SDA_O(),
        .SDA_OE_O(sda_oe), .PIX444_I(24'h123456), .PIX422_I(16'habcd), .HSYNC_I(cnt[1]),
        .VSYNC_I(cnt[5]), .DE_I(cnt[2]), .FIELD_I(fld_in), .PIXEL_REP_I(rep),
        .SPDIF_I(cnt[0]), .I2S_SD_I(cnt[3:0]), .I2S_SCLK_I(cnt[2]), .I2S_LRCLK_I(cnt[6]),
        .MCLK_I(cnt[0]), .PWRDN_PIN_I(pin), .VID_RED_O(red), .VID_GRN_O(), .VID_BLU_O(blu),
        .VID_PRI_OE_O(pri_oe), .VID_BLU_OE_O(blu_oe), .HSYNC_O(), .VSYNC_O(), .DE_O(),
        .FIELD_O(fld), .SYNC_OE_O(sync_oe), .DCLK_O(dclk), .DCLK_OE_O(dclk_oe),
        .SPDIF_O(), .SPDIF_OE_O(spdif_oe), .I2S_SD_O(), .I2S_SCLK_O(), .I2S_LRCLK_O(),
        .MCLK_O(), .I2S_OE_O(i2s_oe), .POWER_DOWN_O(pd));
    vocf_disp u_disp (.clk_i(clk), .dclk_i(dclk), .dclk_oe_i(dclk_oe), .pri_oe_i(pri_oe),
        .red_i(red), .red_o(disp_red));
    task automatic summarize;
        if (failures == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic waitn(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Nine bit times; the line is read in mid-high, clear of the device's update
    task automatic xb(input logic [8:0] d, output logic [8:0] q);
        for (int i = 8; i >= 0; i--) begin
            waitn(2);
            sda_m = d[i];
            waitn(2);
            scl = 1'b1;
            waitn(2);
            q[i] = sda_w;
            waitn(2);
            scl = 1'b0;
        end
    endtask
    task automatic start;
        sda_m = 1'b1;
        waitn(2);
        scl = 1'b1;
        waitn(4);
        sda_m = 1'b0;
        waitn(4);
        scl = 1'b0;
    endtask
    task automatic stop;
        waitn(2);
        sda_m = 1'b0;
        waitn(2);
        scl = 1'b1;
        waitn(4);
        sda_m = 1'b1;
        waitn(4);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        start;
        xb({VOCF_DEV_ADDR, 2'b01}, rx);
        check(rx[0], 1'b0, "address ack");
        xb({a, 1'b1}, rx);
        check(rx[0], 1'b0, "offset ack");
        xb({d, 1'b1}, rx);
        check(rx[0], 1'b0, "data ack");
        stop;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        start;
        xb({VOCF_DEV_ADDR, 2'b01}, rx);
        xb({a, 1'b1}, rx);
        start;
        xb({VOCF_DEV_ADDR, 2'b11}, rx);
        xb(9'h1ff, rx);
        check(rx[8:1], exp, what);
        stop;
    endtask
    // Eight output clock samples, each against the phase of the edge before
    task automatic clk_chk(input logic [1:0] sel, input logic inv, input string what);
        logic [7:0] seen;
        logic [7:0] exp;
        logic [2:0] e;
        for (int i = 0; i < 8; i++) begin
            waitn(1);
            e = ref_ph - 3'h1;
            seen[i] = dclk;
            case (sel)
                VOCF_CLK_HALF: exp[i] = e[2];
                VOCF_CLK_ONE: exp[i] = rep ? e[2] : e[1];
                VOCF_CLK_DOUBLE: exp[i] = e[0];
                default: exp[i] = rep ? (e[2] ^ e[1]) : (e[1] ^ e[0]);
            endcase
            exp[i] = exp[i] ^ inv;
        end
        check(seen, exp, what);
    endtask
    initial begin
        repeat (100000) @(posedge clk);
        failures++;
        summarize;
    end
    initial begin
        waitn(20);
        rst_b = 1'b1;
        waitn(4);
        rd(VOCF_POL_OFS, VOCF_POL_RST, "polarity reset");
        rd(VOCF_CLKFMT_OFS, VOCF_CLKFMT_RST, "format reset");
        rd(VOCF_TRIPD_OFS, VOCF_TRIPD_RST, "three-state reset");
        rd(8'h30, 8'h00, "unmapped read");
        check(fld, 1'b1, "field high");
        check(pd, 1'b1, "power-down high");
        check(disp_red, 8'h12, "displayed red");
        check(blu, 8'h56, "blue 444");
        wr(VOCF_POL_OFS, 8'hff);
        rd(VOCF_POL_OFS, VOCF_POL_MASK, "polarity mask");
        wr(VOCF_POL_OFS, 8'h00);
        check(fld, 1'b0, "field low");
        fld_in = 1'b0;
        waitn(2);
        check(fld, 1'b1, "field inverted");
        wr(VOCF_CLKFMT_OFS, 8'h75);
        check({pri_oe, blu_oe}, 8'h01, "mode 1 enables");
        check(red, 8'h00, "red off");
        wr(VOCF_CLKFMT_OFS, 8'h76);
        check({pri_oe, blu_oe}, 8'h02, "mode 1 primary");
        waitn(8);
        check(disp_red, 8'hab, "displayed luma");
        clk_chk(VOCF_CLK_ONE, 1'b0, "single clock");
        wr(VOCF_CLKFMT_OFS, 8'h36);
        clk_chk(VOCF_CLK_HALF, 1'b0, "half clock");
        wr(VOCF_CLKFMT_OFS, 8'hb6);
        clk_chk(VOCF_CLK_DOUBLE, 1'b0, "double clock");
        wr(VOCF_CLKFMT_OFS, 8'hf6);
        clk_chk(VOCF_CLK_ONE_90, 1'b0, "shifted clock");
        rep = 1'b1;
        clk_chk(VOCF_CLK_ONE_90, 1'b0, "repeated shifted clock");
        rep = 1'b0;
        wr(VOCF_CLKFMT_OFS, 8'h76);
        rep = 1'b1;
        clk_chk(VOCF_CLK_ONE, 1'b0, "repeated single clock");
        rep = 1'b0;
        wr(VOCF_CLKFMT_OFS, 8'h7b);
        check(disp_red, 8'h45, "double-rate red");
        wr(VOCF_POL_OFS, 8'h01);
        clk_chk(VOCF_CLK_ONE, 1'b1, "inverted clock");
        wr(VOCF_TRIPD_OFS, 8'hb0);
        check({sync_oe, dclk_oe, pri_oe, spdif_oe, i2s_oe, pd}, 8'h00, "three-state");
        pin = 1'b0;
        waitn(2);
        check(pd, 1'b1, "power-down active low");
        start;
        xb({~VOCF_DEV_ADDR, 2'b01}, rx);
        check(rx[0], 1'b1, "foreign address");
        stop;
        summarize;
    end
endmodule
